// File: bench/io_port_and_variable_ram_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  $display("unexpected %s expected %h seen %h", nm, e, g); \
  err_count++; end end
module io_port_and_variable_ram_tb
  import var_ram_pkg::*;
;
  logic clock, rst_b, wr_en, rd_en, aux_selected;
  logic [ADDR_W-1:0] addr;
  logic [1:0] access_size;
  logic [WORD_W-1:0] wdata, rdata;
  logic [15:0] m_in, m_out, m_oe, x_in, x_out, x_oe, m_ext, x_ext, m_short;
  int err_count, checks_done;
  io_port_and_variable_ram i_dut (.clock(clock), .rst_b(rst_b),
    .addr(addr), .access_size(access_size), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .main_pin_in(m_in),
    .main_pin_out(m_out), .main_pin_oe(m_oe), .aux_pin_in(x_in),
    .aux_pin_out(x_out), .aux_pin_oe(x_oe), .aux_selected(aux_selected));
  pin_world i_main (.pin_out(m_out), .pin_oe(m_oe), .ext_val(m_ext),
    .short_low(m_short), .level(m_in));
  pin_world i_aux (.pin_out(x_out), .pin_oe(x_oe), .ext_val(x_ext),
    .short_low(16'h0000), .level(x_in));
  // Free-running 200 MHz clock.
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // One-cycle write strobe; returns just after the edge that takes it.
  task automatic wr(input logic [7:0] a, input logic [1:0] s,
    input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    access_size <= s;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clock);
    wr_en <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [1:0] s,
    input logic [15:0] e);
    @(posedge clock);
    addr <= a;
    access_size <= s;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1;
    `CHK("rdata", e, rdata)
  endtask
  // Pins need two synchroniser edges before the level word shows them.
  task automatic settle();
    repeat (3) @(posedge clock);
  endtask
  task automatic test_done();
    if (err_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Main sequence.
  initial begin
    rst_b = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'h00;
    access_size = SIZE_WORD;
    wdata = 16'h0000;
    m_ext = 16'hA5C3;
    x_ext = 16'h3C5A;
    m_short = 16'h0001;
    err_count = 0;
    checks_done = 0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    rd(8'h01, SIZE_WORD, 16'h0000);
    rd(8'h02, SIZE_WORD, 16'h0000);
    rd(8'h05, SIZE_WORD, 16'h0000);
    `CHK("pin_oe", 16'h0000, m_oe)
    rd(8'h00, SIZE_WORD, 16'hA5C2);
    // Latch holds while every pin is an input.
    wr(8'h01, SIZE_WORD, 16'hFFFF);
    `CHK("pin_out", 16'h0000, m_out)
    rd(8'h01, SIZE_WORD, 16'hFFFF);
    wr(8'h02, SIZE_WORD, 16'h00FF);
    `CHK("pin_oe", 16'h00FF, m_oe)
    `CHK("pin_out", 16'h00FF, m_out)
    settle();
    rd(8'h00, SIZE_WORD, 16'hA5FE);
    wr(8'h00, SIZE_WORD, 16'h0000);
    wr(8'h00, SIZE_BYTE, 16'h0011);
    settle();
    rd(8'h00, SIZE_WORD, 16'hA5FE);
    rd(8'h00, SIZE_BYTE, 16'h00FE);
    rd(8'h01, SIZE_BYTE, 16'h00A5);
    rd(8'h00, SIZE_NIB, 16'h000E);
    rd(8'h03, SIZE_NIB, 16'h000A);
    rd(8'h08, SIZE_BIT, 16'h0001);
    rd(8'h00, SIZE_BIT, 16'h0000);
    // Sub-word access to latch and direction words.
    wr(8'h02, SIZE_BYTE, 16'h003C);
    wr(8'h09, SIZE_NIB, 16'h0000);
    wr(8'h2F, SIZE_BIT, 16'h0001);
    rd(8'h01, SIZE_WORD, 16'hFF3C);
    rd(8'h02, SIZE_WORD, 16'h800F);
    `CHK("pin_oe", 16'h800F, m_oe)
    `CHK("pin_out", 16'h800C, m_out)
    // Byte aliasing in the general words.
    wr(8'h03, SIZE_WORD, 16'h1234);
    rd(8'h06, SIZE_BYTE, 16'h0034);
    wr(8'h07, SIZE_BYTE, 16'h00AB);
    rd(8'h03, SIZE_WORD, 16'hAB34);
    wr(8'h0F, SIZE_WORD, 16'hBEEF);
    rd(8'h0F, SIZE_WORD, 16'hBEEF);
    // Oversized values lose their upper bits.
    wr(8'h08, SIZE_BYTE, 16'h0104);
    rd(8'h08, SIZE_BYTE, 16'h0004);
    wr(8'h11, SIZE_NIB, 16'h001F);
    wr(8'h4F, SIZE_BIT, 16'h0003);
    rd(8'h04, SIZE_WORD, 16'h80F4);
    // A byte array in word 5 onward, indexed from zero.
    for (int i = 0; i < 5; i++) wr(8'h0A + 8'(i), SIZE_BYTE, 16'(i * 13));
    for (int i = 0; i < 5; i++) begin
      rd(8'h0A + 8'(i), SIZE_BYTE, 16'(i * 13));
    end
    // Auxiliary bank in, used, toggled out and back.
    wr(BANK_CTRL_ADDR, SIZE_WORD, {14'h0000, BANK_CMD_AUX});
    rd(BANK_CTRL_ADDR, SIZE_WORD, 16'h0001);
    settle();
    rd(8'h00, SIZE_WORD, 16'h3C5A);
    rd(8'h01, SIZE_WORD, 16'h0000);
    wr(8'h01, SIZE_WORD, 16'h5555);
    wr(8'h02, SIZE_WORD, 16'h00FF);
    `CHK("aux_pin_out", 16'h0055, x_out)
    `CHK("aux_pin_oe", 16'h00FF, x_oe)
    `CHK("pin_oe", 16'h800F, m_oe)
    wr(BANK_CTRL_ADDR, SIZE_WORD, {14'h0000, BANK_CMD_TOGGLE});
    `CHK("aux_sel", 1'b0, aux_selected)
    rd(8'h01, SIZE_WORD, 16'hFF3C);
    wr(BANK_CTRL_ADDR, SIZE_WORD, {14'h0000, BANK_CMD_TOGGLE});
    rd(8'h01, SIZE_WORD, 16'h5555);
    // Command code zero is ignored and leaves the bank as it was.
    wr(BANK_CTRL_ADDR, SIZE_WORD, 16'h0000);
    rd(BANK_CTRL_ADDR, SIZE_WORD, 16'h0001);
    wr(BANK_CTRL_ADDR, SIZE_WORD, {14'h0000, BANK_CMD_MAIN});
    rd(BANK_CTRL_ADDR, SIZE_WORD, 16'h0000);
    // A second reset clears everything again.
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (20) @(posedge clock);
    rst_b <= 1'b1;
    rd(8'h03, SIZE_WORD, 16'h0000);
    `CHK("aux_pin_oe", 16'h0000, x_oe)
    `CHK("pin_out", 16'h0000, m_out)
    test_done();
  end
endmodule
`default_nettype wire

// File: bench/pin_world.sv
`timescale 1ns/100ps
`default_nettype none
// Far-side circuitry on one bank of pins.
module pin_world (
  // Device side.
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  // Outside source and hard shorts to ground.
  input wire logic [15:0] ext_val,
  input wire logic [15:0] short_low,
  // Resolved pin levels.
  output logic [15:0] level
);
  // A short beats the driver, which is how a real pin behaves.
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (short_low[i]) level[i] = 1'b0;
      else if (pin_oe[i]) level[i] = pin_out[i];
      else level[i] = ext_val[i];
    end
  end
endmodule
`default_nettype wire

// File: design/io_port_and_variable_ram.sv
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module io_port_and_variable_ram
  import var_ram_pkg::*;
#(
  parameter int NUM_PINS = 16
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Access port: element address in units of the chosen size.
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [1:0] access_size,
  input wire logic [WORD_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [WORD_W-1:0] rdata,
  // Main bank pins.
  input wire logic [NUM_PINS-1:0] main_pin_in,
  output logic [NUM_PINS-1:0] main_pin_out,
  output logic [NUM_PINS-1:0] main_pin_oe,
  // Auxiliary bank pins.
  input wire logic [NUM_PINS-1:0] aux_pin_in,
  output logic [NUM_PINS-1:0] aux_pin_out,
  output logic [NUM_PINS-1:0] aux_pin_oe,
  // Bank status.
  output logic aux_selected
);
  logic [WORD_W-1:0] mem_reg [NUM_WORDS];
  logic [WORD_W-1:0] aux_latch_reg;
  logic [WORD_W-1:0] aux_dir_reg;
  logic aux_sel_reg;
  logic [WORD_W-1:0] rdata_reg;
  logic [NUM_PINS-1:0] main_level;
  logic [NUM_PINS-1:0] aux_level;

  // Both pin groups pass the synchroniser before being seen.
  pin_sync #(.WIDTH(NUM_PINS)) u_main_sync (
    .clock(clock),
    .rst_b(rst_b),
    .pin_async(main_pin_in),
    .pin_sync_out(main_level)
  );
  pin_sync #(.WIDTH(NUM_PINS)) u_aux_sync (
    .clock(clock),
    .rst_b(rst_b),
    .pin_async(aux_pin_in),
    .pin_sync_out(aux_level)
  );

  // Decode the element address into a word index and a bit offset.
  // Elements are contiguous, so an index past a word runs into the next.
  logic [ADDR_W+3:0] bit_addr;
  logic [3:0] word_idx;
  logic [3:0] bit_off;
  logic [WORD_W-1:0] size_mask;
  logic bank_access;
  assign bit_addr = (access_size == SIZE_BIT) ? {4'h0, addr} :
                    (access_size == SIZE_NIB) ? {2'h0, addr, 2'h0} :
                    (access_size == SIZE_BYTE) ? {1'h0, addr, 3'h0} :
                    {addr, 4'h0};
  assign word_idx = bit_addr[7:4];
  assign bit_off = bit_addr[3:0];
  assign size_mask = (access_size == SIZE_BIT) ? 16'h0001 :
                     (access_size == SIZE_NIB) ? 16'h000F :
                     (access_size == SIZE_BYTE) ? 16'h00FF :
                     16'hFFFF;
  assign bank_access = (access_size == SIZE_WORD) &&
                       (addr == BANK_CTRL_ADDR);

  // Live view of each word; I/O words come from the selected bank.
  logic [WORD_W-1:0] view [NUM_WORDS];
  genvar g;
  generate
    for (g = 0; g < NUM_WORDS; g++) begin : g_view
      if (g == WORD_PIN_LEVEL) begin : g_lvl
        assign view[g] = aux_sel_reg ? aux_level : main_level;
      end else if (g == WORD_OUT_LATCH) begin : g_lat
        assign view[g] = aux_sel_reg ? aux_latch_reg : mem_reg[g];
      end else if (g == WORD_DIRECTION) begin : g_dir
        assign view[g] = aux_sel_reg ? aux_dir_reg : mem_reg[g];
      end else begin : g_gen
        assign view[g] = mem_reg[g];
      end
    end
  endgenerate

  // Read extracts the element by shift and mask.
  logic [WORD_W-1:0] rd_word;
  logic [WORD_W-1:0] rd_elem;
  assign rd_word = view[word_idx];
  assign rd_elem = (rd_word >> bit_off) & size_mask;

  // Write merges the truncated value into the target word.
  logic [WORD_W-1:0] wr_mask;
  logic [WORD_W-1:0] wr_bits;
  logic [WORD_W-1:0] wr_merged;
  logic wr_word_ok;
  assign wr_mask = size_mask << bit_off;
  assign wr_bits = (wdata & size_mask) << bit_off;
  assign wr_merged = (rd_word & ~wr_mask) | wr_bits;
  assign wr_word_ok = wr_en && !bank_access &&
                      (word_idx != WORD_PIN_LEVEL);

  // Which store takes the merged word.
  logic aux_io_wr;
  assign aux_io_wr = wr_word_ok && aux_sel_reg &&
                     ((word_idx == WORD_OUT_LATCH) ||
                      (word_idx == WORD_DIRECTION));

  // Variable RAM; every location clears at reset.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        mem_reg[i] <= WORD_RESET;
      end
    end else if (wr_word_ok && !aux_io_wr) begin
      mem_reg[word_idx] <= wr_merged;
    end
  end

  // Auxiliary latch and direction words.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aux_latch_reg <= WORD_RESET;
      aux_dir_reg <= WORD_RESET;
    end else if (aux_io_wr && (word_idx == WORD_OUT_LATCH)) begin
      aux_latch_reg <= wr_merged;
    end else if (aux_io_wr) begin
      aux_dir_reg <= wr_merged;
    end
  end

  // Bank switching commands: main, auxiliary or toggle.
  logic aux_sel_next;
  assign aux_sel_next =
    !(wr_en && bank_access) ? aux_sel_reg :
    (wdata[1:0] == BANK_CMD_MAIN) ? 1'b0 :
    (wdata[1:0] == BANK_CMD_AUX) ? 1'b1 :
    (wdata[1:0] == BANK_CMD_TOGGLE) ? !aux_sel_reg :
    aux_sel_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      aux_sel_reg <= 1'b0;
    end else begin
      aux_sel_reg <= aux_sel_next;
    end
  end

  // Read data stands in the cycle after the strobe and is zero otherwise.
  logic [WORD_W-1:0] rdata_next;
  assign rdata_next = !rd_en ? WORD_RESET :
                      bank_access ? {15'h0000, aux_sel_reg} :
                      rd_elem;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdata_reg <= WORD_RESET;
    end else begin
      rdata_reg <= rdata_next;
    end
  end
  assign rdata = rdata_reg;
  assign aux_selected = aux_sel_reg;

  // Pins: drive only where the direction bit is one. The latch keeps its
  // value for input pins so it appears the moment the pin turns output.
  assign main_pin_oe = mem_reg[WORD_DIRECTION];
  assign main_pin_out = mem_reg[WORD_OUT_LATCH] &
                        mem_reg[WORD_DIRECTION];
  assign aux_pin_oe = aux_dir_reg;
  assign aux_pin_out = aux_latch_reg & aux_dir_reg;

  // Helper for the reset check: one flag per RAM word, set if any bit is.
  // Looping per word keeps the check honest for every location at once.
  logic [NUM_WORDS-1:0] word_nonzero;
  genvar k;
  generate
    for (k = 0; k < NUM_WORDS; k++) begin : g_nonzero
      assign word_nonzero[k] = |mem_reg[k];
    end
  endgenerate

  // Multi-step behaviours. The synchroniser needs two edges after reset
  // before its output follows the pins, so checks on the level word wait.
  sequence s_levels_settled;
    (rst_b) [*3] ##0 !aux_sel_reg;
  endsequence
  sequence s_pin0_grounded;
    (main_pin_in[0] == 1'b0) [*3] ##0 !aux_sel_reg;
  endsequence
  // Reset is checked on its second edge, as the first may meet power-up X.
  sequence s_reset_held;
    (!rst_b) [*2];
  endsequence
  sequence s_main_latch_write;
    wr_en && !aux_sel_reg && access_size == SIZE_WORD &&
    addr == {4'h0, WORD_OUT_LATCH};
  endsequence
  sequence s_main_dir_write;
    wr_en && !aux_sel_reg && access_size == SIZE_WORD &&
    addr == {4'h0, WORD_DIRECTION};
  endsequence
  sequence s_aux_latch_write;
    wr_en && aux_sel_reg && access_size == SIZE_WORD &&
    addr == {4'h0, WORD_OUT_LATCH};
  endsequence
  sequence s_bank_cmd;
    wr_en && bank_access;
  endsequence

  // Checks.
  a_level_follows_pin: assert property (
    @(posedge clock) disable iff (!rst_b)
    s_levels_settled |-> view[WORD_PIN_LEVEL] == $past(main_pin_in, 2))
    else $error("level word lost pin");
  a_short_reads_low: assert property (
    @(posedge clock) disable iff (!rst_b)
    s_pin0_grounded |-> !view[WORD_PIN_LEVEL][0])
    else $error("grounded pin read high");
  a_undriven_input: assert property (
    @(posedge clock) disable iff (!rst_b)
    main_pin_oe == mem_reg[WORD_DIRECTION] &&
    ((main_pin_out & ~main_pin_oe) == '0))
    else $error("input pin driven");
  a_latch_kept: assert property (
    @(posedge clock) disable iff (!rst_b)
    s_main_latch_write |=> mem_reg[WORD_OUT_LATCH] == $past(wdata))
    else $error("latch did not store");
  a_read_element: assert property (
    @(posedge clock) disable iff (!rst_b)
    rd_en && !bank_access |=> rdata == $past(rd_elem) &&
    (rdata & ~$past(size_mask)) == '0)
    else $error("bad read element");
  a_byte_alias: assert property (
    @(posedge clock) disable iff (!rst_b)
    wr_word_ok && !aux_io_wr && access_size == SIZE_BYTE && addr[0]
    |=> mem_reg[$past(word_idx)][15:8] == $past(wdata[7:0]) &&
    mem_reg[$past(word_idx)][7:0] == $past(rd_word[7:0]))
    else $error("byte alias broken");
  a_truncate_write: assert property (
    @(posedge clock) disable iff (!rst_b)
    wr_word_ok && !aux_io_wr && access_size == SIZE_NIB
    |=> ((mem_reg[$past(addr[5:2])] >> {$past(addr[1:0]), 2'h0}) &
    16'h000F) == {12'h000, $past(wdata[3:0])})
    else $error("write not truncated");
  a_level_readonly: assert property (
    @(posedge clock) disable iff (!rst_b)
    wr_en && word_idx == WORD_PIN_LEVEL && !bank_access
    |=> $stable(mem_reg[WORD_PIN_LEVEL]) && $stable(aux_latch_reg) &&
    $stable(aux_dir_reg) && $stable(mem_reg[WORD_OUT_LATCH]) &&
    $stable(mem_reg[WORD_DIRECTION]))
    else $error("level word written");
  a_bank_toggle: assert property (
    @(posedge clock) disable iff (!rst_b)
    s_bank_cmd ##0 wdata[1:0] == BANK_CMD_TOGGLE
    |=> aux_sel_reg != $past(aux_sel_reg))
    else $error("toggle failed");
  a_pin_next_edge: assert property (
    @(posedge clock) disable iff (!rst_b)
    s_main_dir_write |=> main_pin_oe == $past(wdata))
    else $error("direction late");
  a_reset_clears: assert property (
    @(posedge clock)
    s_reset_held |-> word_nonzero == '0 && !aux_sel_reg &&
    aux_latch_reg == WORD_RESET && aux_dir_reg == WORD_RESET &&
    rdata_reg == WORD_RESET)
    else $error("reset left state");
  a_high_byte_pins: assert property (
    @(posedge clock) disable iff (!rst_b)
    rd_en && !aux_sel_reg && access_size == SIZE_BYTE && addr == 8'h01
    |=> rdata == {8'h00, $past(main_level[15:8])})
    else $error("high byte pin map");
  a_bit_lands: assert property (
    @(posedge clock) disable iff (!rst_b)
    wr_word_ok && !aux_io_wr && access_size == SIZE_BIT
    |=> mem_reg[$past(addr[7:4])][$past(addr[3:0])] == $past(wdata[0]))
    else $error("bit write misplaced");
  a_byte_lands: assert property (
    @(posedge clock) disable iff (!rst_b)
    wr_word_ok && !aux_io_wr && access_size == SIZE_BYTE
    |=> ((mem_reg[$past(addr[4:1])] >> {$past(addr[0]), 3'h0}) &
    16'h00FF) == {8'h00, $past(wdata[7:0])})
    else $error("byte write misplaced");
  a_gp_word_store: assert property (
    @(posedge clock) disable iff (!rst_b)
    wr_en && access_size == SIZE_WORD &&
    addr > {4'h0, WORD_DIRECTION} && addr < 8'(NUM_WORDS)
    |=> mem_reg[$past(addr[3:0])] == $past(wdata))
    else $error("general word lost");
  a_aux_store: assert property (
    @(posedge clock) disable iff (!rst_b)
    s_aux_latch_write |=> aux_latch_reg == $past(wdata) &&
    $stable(mem_reg[WORD_OUT_LATCH]))
    else $error("aux latch missed");
  a_bank_aux: assert property (
    @(posedge clock) disable iff (!rst_b)
    s_bank_cmd ##0 wdata[1:0] == BANK_CMD_AUX |=> aux_sel_reg)
    else $error("aux bank not selected");
  a_bank_main: assert property (
    @(posedge clock) disable iff (!rst_b)
    s_bank_cmd ##0 wdata[1:0] == BANK_CMD_MAIN |=> !aux_sel_reg)
    else $error("main bank not selected");
  a_nib_zero_ext: assert property (
    @(posedge clock) disable iff (!rst_b)
    rd_en && !bank_access && access_size == SIZE_NIB
    |=> rdata[15:4] == 12'h000)
    else $error("nibble read too wide");
endmodule
`default_nettype wire

// File: design/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module pin_sync
  import var_ram_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Asynchronous pin levels in, synchronised levels out.
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_sync_out
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // Two stages per pin; only the second stage is ever read.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
    end else begin
      stage1_reg <= pin_async;
      stage2_reg <= stage1_reg;
    end
  end

  assign pin_sync_out = stage2_reg;
endmodule
`default_nettype wire

// File: design/var_ram_pkg.sv
package var_ram_pkg;
  localparam int WORD_W = 16;
  localparam int NUM_WORDS = 16;
  localparam int ADDR_W = 8;
  // Element size codes for the access port.
  localparam logic [1:0] SIZE_BIT = 2'h0;
  localparam logic [1:0] SIZE_NIB = 2'h1;
  localparam logic [1:0] SIZE_BYTE = 2'h2;
  localparam logic [1:0] SIZE_WORD = 2'h3;
  // Word locations of the I/O words.
  localparam logic [3:0] WORD_PIN_LEVEL = 4'h0;
  localparam logic [3:0] WORD_OUT_LATCH = 4'h1;
  localparam logic [3:0] WORD_DIRECTION = 4'h2;
  // Bank control register, reached at a word address of its own.
  localparam logic [ADDR_W-1:0] BANK_CTRL_ADDR = 8'hFF;
  localparam logic [1:0] BANK_CMD_MAIN = 2'h1;
  localparam logic [1:0] BANK_CMD_AUX = 2'h2;
  localparam logic [1:0] BANK_CMD_TOGGLE = 2'h3;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
endpackage
